// file: core/cacc_pkg.sv
// Constants and register map for the counter array capture/compare block
// Functional notes
// - Comparator enable bit turns each module's 16-bit compare on; resets clear.
// - Rise latch enable captures counter on each rising pin edge.
// - Fall latch enable captures counter on each falling pin edge.
// - Compare hit flag enable sets the event flag on counter match.
// - Pin flip bit inverts the module pin on each counter match.
// - Pulse width enable routes PWM output to the pin; clear gives the flip level, driven only if flip is set.
// - Module interrupt enable passes the event flag to the interrupt request.
// - Both edge bits set give capture on either pin transition.
// - Only fall latch set gives capture on falling edges only.
// - Comparator, hit flag and flip set give high speed toggling output.
// - Capture loads counter high and low bytes into module value bytes.
// - After capture, interrupt is raised when flag and enable are set.
// - Compare match raises interrupt when flag and enable are set.
// - Software timer compares without toggling the pin.
// - Counter is readable and writable as separate low and high bytes.
// - Event flags are set by hardware only and cleared by software.
// - Counter advances only while the run bit is set.
// - PWM pin low while counter low byte is below the 9-bit duty, else high.
// - On low byte wrap, active duty reloads from reload bit and value high.
package cacc_pkg;
  localparam int unsigned NUM_MODULES = 4;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] ADDR_COUNTER_LOW = 5'h00;
  localparam logic [4:0] ADDR_COUNTER_HIGH = 5'h01;
  localparam logic [4:0] ADDR_CONTROL = 5'h02;
  // Per module: value low, value high, mode, duty aux at base + 4*n
  localparam logic [4:0] ADDR_MODULE_BASE = 5'h04;
  localparam logic [1:0] SUB_VALUE_LOW = 2'h0;
  localparam logic [1:0] SUB_VALUE_HIGH = 2'h1;
  localparam logic [1:0] SUB_MODE = 2'h2;
  localparam logic [1:0] SUB_DUTY_AUX = 2'h3;
  localparam int unsigned MODE_CMP_EN = 6;
  localparam int unsigned MODE_RISE = 5;
  localparam int unsigned MODE_FALL = 4;
  localparam int unsigned MODE_HIT = 3;
  localparam int unsigned MODE_FLIP = 2;
  localparam int unsigned MODE_PWM = 1;
  localparam int unsigned MODE_IRQ = 0;
  localparam logic [7:0] MODE_MASK = 8'h7f;
  localparam int unsigned CTRL_RUN = 6;
  localparam int unsigned AUX_ACTIVE = 0;
  localparam int unsigned AUX_RELOAD = 1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] WORD_ONE = 16'h0001;
endpackage : cacc_pkg

// file: core/cacc_mod_if.sv
// Interface between the array top and one capture/compare module
`timescale 1ns/100ps
`default_nettype none
interface cacc_mod_if;
  logic [7:0] mode;
  logic [15:0] value;
  logic duty_active;
  logic [15:0] count;
  logic pin_rise;
  logic pin_fall;
  logic hit_event;
  logic capture_event;
  logic pin_out;
  modport top (output mode, value, duty_active, count, pin_rise, pin_fall,
               input hit_event, capture_event, pin_out);
  modport unit (input mode, value, duty_active, count, pin_rise, pin_fall,
                output hit_event, capture_event, pin_out);
endinterface : cacc_mod_if
`default_nettype wire

// file: core/cacc_module.sv
// One capture/compare module: capture, compare, toggle and PWM pin logic
`timescale 1ns/100ps
`default_nettype none
module cacc_module (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  cacc_mod_if.unit m
);
  typedef struct packed {
    logic flip_level;
    logic last_match;
  } cacc_unit_s;
  cacc_unit_s st_reg, st_next;
  logic match;
  logic pwm_level;
  logic rise_cap;
  logic fall_cap;
  always_comb begin
    // Only the first counter tick at a value counts as a hit, not every cycle it stands
    match = m.mode[cacc_pkg::MODE_CMP_EN] && (m.count == m.value);
    rise_cap = m.mode[cacc_pkg::MODE_RISE] && m.pin_rise;
    fall_cap = m.mode[cacc_pkg::MODE_FALL] && m.pin_fall;
    pwm_level = ({1'b0, m.count[7:0]} >= {m.duty_active, m.value[7:0]});
    st_next = st_reg;
    st_next.last_match = match;
    if (match && !st_reg.last_match && m.mode[cacc_pkg::MODE_FLIP]) begin
      st_next.flip_level = !st_reg.flip_level;
    end
  end
  assign m.hit_event = match && !st_reg.last_match && m.mode[cacc_pkg::MODE_HIT];
  assign m.capture_event = rise_cap || fall_cap;
  assign m.pin_out = m.mode[cacc_pkg::MODE_PWM] ? pwm_level : st_reg.flip_level;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end
  a_flip_on_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && match && !st_reg.last_match && m.mode[cacc_pkg::MODE_FLIP]) |=>
    (st_reg.flip_level != $past(st_reg.flip_level))) else $error("pin did not flip on hit");
  a_no_flip_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!m.mode[cacc_pkg::MODE_FLIP]) |=> $stable(st_reg.flip_level)) else $error("pin flipped while off");
  a_cmp_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !m.mode[cacc_pkg::MODE_CMP_EN] |-> !m.hit_event) else $error("hit without comparator");
endmodule : cacc_module
`default_nettype wire

// file: core/cacc_top.sv
// Counter array top: shared counter, register port, pin synchronisers, four modules
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cacc_top #(
  parameter int unsigned NUM_MOD = cacc_pkg::NUM_MODULES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [cacc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_MOD-1:0] module_pin_in,
  output logic [NUM_MOD-1:0] module_pin_out,
  output logic [NUM_MOD-1:0] module_pin_oe_n,
  output logic irq
);
  // Offsets of the register map exist for four modules only
  if (NUM_MOD != cacc_pkg::NUM_MODULES) begin : g_num_check
    $error("Register map serves exactly four modules");
  end
  typedef struct packed {
    logic [15:0] count;
    logic run;
    logic [3:0] flags;
    logic [3:0][7:0] mode;
    logic [3:0][15:0] value;
    logic [3:0] duty_active;
    logic [3:0] duty_reload;
    logic [3:0] pin_sync1;
    logic [3:0] pin_sync2;
    logic [3:0] pin_prev;
    logic [3:0] pin_out;
    logic [7:0] rdata;
  } cacc_top_s;
  cacc_top_s st_reg, st_next;
  logic [3:0] hit_ev;
  logic [3:0] cap_ev;
  logic [3:0] unit_pin;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [3:0] pwm_on;
  logic wrap;
  logic in_mod;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mod
      cacc_mod_if mif ();
      assign mif.mode = st_reg.mode[gi];
      assign mif.value = st_reg.value[gi];
      assign mif.duty_active = st_reg.duty_active[gi];
      assign mif.count = st_reg.count;
      assign mif.pin_rise = pin_rise[gi];
      assign mif.pin_fall = pin_fall[gi];
      assign hit_ev[gi] = mif.hit_event;
      assign cap_ev[gi] = mif.capture_event;
      assign unit_pin[gi] = mif.pin_out;
      assign pwm_on[gi] = st_reg.mode[gi][cacc_pkg::MODE_PWM];
      cacc_module u_mod (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .m(mif.unit)
      );
    end
  endgenerate
  // Edge detection reads only the second synchroniser stage
  assign pin_rise = st_reg.pin_sync2 & ~st_reg.pin_prev;
  assign pin_fall = ~st_reg.pin_sync2 & st_reg.pin_prev;
  assign wrap = st_reg.run && (st_reg.count[7:0] == cacc_pkg::BYTE_MAX);
  // Module window ends with the fourth module; addresses above it must not alias module 0
  assign in_mod = ((reg_addr >= cacc_pkg::ADDR_MODULE_BASE) && (reg_addr[4] == 1'b0))
                  || (reg_addr[4] && (reg_addr[3:2] == 2'b00));
  logic [1:0] idx;
  assign idx = 2'(reg_addr[4:2] - 3'h1);
  always_comb begin
    st_next = st_reg;
    st_next.pin_sync1 = module_pin_in;
    st_next.pin_sync2 = st_reg.pin_sync1;
    st_next.pin_prev = st_reg.pin_sync2;
    st_next.pin_out = unit_pin;
    if (st_reg.run) begin
      st_next.count = st_reg.count + cacc_pkg::WORD_ONE;
    end
    if (wrap) begin
      st_next.duty_active = st_reg.duty_reload;
      for (int i = 0; i < 4; i++) begin
        if (pwm_on[i]) begin
          st_next.value[i][7:0] = st_reg.value[i][15:8];
        end
      end
    end
    st_next.rdata = cacc_pkg::BYTE_ZERO;
    if (reg_write) begin
      if (reg_addr == cacc_pkg::ADDR_COUNTER_LOW) begin
        st_next.count[7:0] = reg_wdata;
      end else if (reg_addr == cacc_pkg::ADDR_COUNTER_HIGH) begin
        st_next.count[15:8] = reg_wdata;
      end else if (reg_addr == cacc_pkg::ADDR_CONTROL) begin
        st_next.run = reg_wdata[cacc_pkg::CTRL_RUN];
        // Software may only clear; a zero written clears the flag
        st_next.flags = st_reg.flags & reg_wdata[3:0];
      end else if (in_mod) begin
        unique case (reg_addr[1:0])
          cacc_pkg::SUB_VALUE_LOW: st_next.value[idx][7:0] = reg_wdata;
          cacc_pkg::SUB_VALUE_HIGH: st_next.value[idx][15:8] = reg_wdata;
          cacc_pkg::SUB_MODE: st_next.mode[idx] = reg_wdata & cacc_pkg::MODE_MASK;
          cacc_pkg::SUB_DUTY_AUX: begin
            st_next.duty_active[idx] = reg_wdata[cacc_pkg::AUX_ACTIVE];
            st_next.duty_reload[idx] = reg_wdata[cacc_pkg::AUX_RELOAD];
          end
        endcase
      end
    end
    // Hardware set wins over a software clear in the same cycle
    for (int i = 0; i < 4; i++) begin
      if (hit_ev[i] || cap_ev[i]) begin
        st_next.flags[i] = 1'b1;
      end
      if (cap_ev[i]) begin
        st_next.value[i] = st_reg.count;
      end
    end
    if (reg_read) begin
      if (reg_addr == cacc_pkg::ADDR_COUNTER_LOW) begin
        st_next.rdata = st_reg.count[7:0];
      end else if (reg_addr == cacc_pkg::ADDR_COUNTER_HIGH) begin
        st_next.rdata = st_reg.count[15:8];
      end else if (reg_addr == cacc_pkg::ADDR_CONTROL) begin
        st_next.rdata = {1'b0, st_reg.run, 2'b00, st_reg.flags};
      end else if (in_mod) begin
        unique case (reg_addr[1:0])
          cacc_pkg::SUB_VALUE_LOW: st_next.rdata = st_reg.value[idx][7:0];
          cacc_pkg::SUB_VALUE_HIGH: st_next.rdata = st_reg.value[idx][15:8];
          cacc_pkg::SUB_MODE: st_next.rdata = st_reg.mode[idx];
          cacc_pkg::SUB_DUTY_AUX: st_next.rdata = {6'h00, st_reg.duty_reload[idx], st_reg.duty_active[idx]};
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end
  assign reg_rdata = st_reg.rdata;
  assign module_pin_out = st_reg.pin_out;
  // Pin driven whenever a PWM or toggle function owns it; otherwise an input
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      module_pin_oe_n[i] = !(st_reg.mode[i][cacc_pkg::MODE_PWM] || st_reg.mode[i][cacc_pkg::MODE_FLIP]);
    end
  end
  logic [3:0] irq_vec;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      irq_vec[i] = st_reg.flags[i] && st_reg.mode[i][cacc_pkg::MODE_IRQ];
    end
  end
  assign irq = |irq_vec;
  a_run_stops_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !st_reg.run && !reg_write) |=> $stable(st_reg.count)) else $error("counter moved while stopped");
  a_run_counts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && st_reg.run && !reg_write) |=> (st_reg.count == 16'($past(st_reg.count) + 16'h0001))) else
    $error("counter did not advance");
  a_capture_loads: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && cap_ev[0]) |=> (st_reg.value[0] == $past(st_reg.count)) && st_reg.flags[0]) else
    $error("capture did not load counter");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_reg.flags[1] && !(reg_write && reg_addr == cacc_pkg::ADDR_CONTROL)) |=> st_reg.flags[1]) else
    $error("flag cleared without software");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq == |(st_reg.flags & {st_reg.mode[3][0], st_reg.mode[2][0], st_reg.mode[1][0], st_reg.mode[0][0]})) else
    $error("interrupt gating wrong");
  a_no_rise_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pin_rise[1] && !st_reg.mode[1][cacc_pkg::MODE_RISE]) |-> !cap_ev[1]) else $error("rising capture while off");
  a_fall_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && pin_fall[1] && st_reg.mode[1][cacc_pkg::MODE_FALL]) |=> st_reg.flags[1]) else
    $error("falling capture missed");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en [*3] |-> (st_reg.pin_sync2 == $past(module_pin_in, 2))) else $error("synchroniser depth wrong");
  a_pwm_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wrap && pwm_on[1]) |=> (st_reg.value[1][7:0] == $past(st_reg.value[1][15:8]))) else
    $error("duty not reloaded");
  a_hit_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && hit_ev[3]) |=> st_reg.flags[3]) else $error("match did not set flag");
  a_both_edges: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && (pin_rise[2] || pin_fall[2]) && st_reg.mode[2][cacc_pkg::MODE_RISE] &&
    st_reg.mode[2][cacc_pkg::MODE_FALL]) |=> (st_reg.value[2] == $past(st_reg.count))) else
    $error("transition capture missed");
  // All register writes are excluded: a mode write may drop the enable in the same cycle
  a_irq_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && cap_ev[0] && st_reg.mode[0][cacc_pkg::MODE_IRQ] && !reg_write) |=> irq) else
    $error("capture raised no interrupt");
  a_irq_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && hit_ev[3] && st_reg.mode[3][cacc_pkg::MODE_IRQ] && !reg_write) |=> irq) else
    $error("match raised no interrupt");
  a_pwm_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && pwm_on[1] && ({1'b0, st_reg.count[7:0]} < {st_reg.duty_active[1], st_reg.value[1][7:0]})) |=>
    !module_pin_out[1]) else $error("pwm pin high below duty");
  a_pwm_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && pwm_on[1] && ({1'b0, st_reg.count[7:0]} >= {st_reg.duty_active[1], st_reg.value[1][7:0]})) |=>
    module_pin_out[1]) else $error("pwm pin low at or above duty");
  a_ninth_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wrap && !reg_write) |=> (st_reg.duty_active == $past(st_reg.duty_reload))) else
    $error("ninth duty bit not reloaded");
  a_count_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && reg_read && reg_addr == cacc_pkg::ADDR_COUNTER_LOW) |=>
    (reg_rdata == $past(st_reg.count[7:0]))) else $error("counter low byte read wrong");
  a_run_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && reg_write && reg_addr == cacc_pkg::ADDR_CONTROL) |=>
    (st_reg.run == $past(reg_wdata[cacc_pkg::CTRL_RUN]))) else $error("run bit write lost");
  // A frozen block must not lose captures or matches half way, so nothing moves at all
  a_frozen_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_en |=> $stable(st_reg)) else $error("state moved while frozen");
  c_capture: cover property (@(posedge sys_clk) cap_ev[0]);
  c_hit: cover property (@(posedge sys_clk) hit_ev[0]);
  c_wrap: cover property (@(posedge sys_clk) wrap && pwm_on[1]);
  c_irq: cover property (@(posedge sys_clk) $rose(irq));
endmodule : cacc_top
`default_nettype wire

// file: verification/cacc_testbench.sv
// Self-checking testbench for the counter array capture/compare block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] module_pin_in = 4'h0;
  logic [3:0] module_pin_out;
  logic [3:0] module_pin_oe_n;
  logic irq;
  logic clk_en = 1'b1;
  int num_errors = 0;
  int tests_run = 0;
  localparam logic [4:0] CTL = cacc_pkg::ADDR_CONTROL;

  always #10 sys_clk = ~sys_clk;

  // Clock enable is driven so that a frozen counter can be checked
  cacc_top cacc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .module_pin_in(module_pin_in), .module_pin_out(module_pin_out),
    .module_pin_oe_n(module_pin_oe_n), .irq(irq));

  function automatic logic [4:0] ma(input int n, input logic [1:0] s);
    return cacc_pkg::ADDR_MODULE_BASE + 5'(4 * n) + {3'b000, s};
  endfunction

  task automatic summarize();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  task automatic set_cnt(input logic [15:0] v);
    wr(cacc_pkg::ADDR_COUNTER_LOW, v[7:0]);
    wr(cacc_pkg::ADDR_COUNTER_HIGH, v[15:8]);
  endtask

  // Synchroniser plus edge detect needs a few edges before the flag lands
  task automatic cap(input int n, input logic [7:0] md, input logic lv, input logic [15:0] c, input logic hit);
    wr(ma(n, cacc_pkg::SUB_MODE), md);
    set_cnt(c);
    wr(CTL, 8'h00);
    @(posedge sys_clk);
    module_pin_in[n] <= lv;
    cyc(8);
    rchk(CTL, 8'(hit) << n, "capture flag");
    if (hit) begin
      rchk(ma(n, cacc_pkg::SUB_VALUE_LOW), c[7:0], "capture low");
      rchk(ma(n, cacc_pkg::SUB_VALUE_HIGH), c[15:8], "capture high");
    end
  endtask

  task automatic t_reset();
    for (int n = 0; n < 4; n++) begin
      rchk(ma(n, cacc_pkg::SUB_MODE), 8'h00, "mode reset");
    end
    rchk(CTL, 8'h00, "control reset");
    rchk(5'h03, 8'h00, "unmapped read");
    rchk(5'h14, 8'h00, "unmapped read");
    // A write above the module window must not alias module 0
    wr(5'h14, 8'hff);
    rchk(ma(0, cacc_pkg::SUB_VALUE_LOW), 8'h00, "unmapped write");
    wr(ma(0, cacc_pkg::SUB_MODE), 8'h80);
    rchk(ma(0, cacc_pkg::SUB_MODE), 8'h00, "mode bit 7");
    chk({4'h0, module_pin_oe_n}, 8'h0f, "oe_n reset");
    chk({7'h00, irq}, 8'h00, "irq reset");
    $display("test reset done");
  endtask

  task automatic t_counter();
    logic [7:0] l1;
    logic [7:0] l2;
    set_cnt(16'h1234);
    rchk(cacc_pkg::ADDR_COUNTER_LOW, 8'h34, "counter low");
    rchk(cacc_pkg::ADDR_COUNTER_HIGH, 8'h12, "counter high");
    wr(CTL, 8'h40);
    cyc(10);
    // Five frozen edges leave twelve counting edges up to the stop write, not seventeen
    clk_en <= 1'b0;
    cyc(5);
    clk_en <= 1'b1;
    wr(CTL, 8'h00);
    rd(cacc_pkg::ADDR_COUNTER_LOW, l1);
    cyc(5);
    rd(cacc_pkg::ADDR_COUNTER_LOW, l2);
    chk(l1, 8'h40, "counter ran and froze");
    chk(l2, l1, "counter stopped");
    $display("test counter done");
  endtask

  task automatic t_capture();
    cap(0, 8'h21, 1'b1, 16'h1234, 1'b1);
    chk({7'h00, irq}, 8'h01, "capture irq");
    cap(0, 8'h21, 1'b0, 16'h5678, 1'b0);
    cap(1, 8'h10, 1'b1, 16'h0a0b, 1'b0);
    cap(1, 8'h10, 1'b0, 16'h0a0b, 1'b1);
    cap(2, 8'h30, 1'b1, 16'h1111, 1'b1);
    cap(2, 8'h30, 1'b0, 16'h2222, 1'b1);
    cap(3, 8'h20, 1'b1, 16'h3333, 1'b1);
    chk({7'h00, irq}, 8'h00, "irq masked");
    $display("test capture done");
  endtask

  // Hit without comparator, flip without hit, toggle output and timer all at once
  task automatic t_compare();
    logic [7:0] md [4] = '{8'h4c, 8'h08, 8'h44, 8'h49};
    logic [7:0] vl [4] = '{8'h05, 8'h08, 8'h07, 8'h10};
    set_cnt(16'h0000);
    for (int n = 0; n < 4; n++) begin
      wr(ma(n, cacc_pkg::SUB_VALUE_HIGH), 8'h00);
      wr(ma(n, cacc_pkg::SUB_VALUE_LOW), vl[n]);
      wr(ma(n, cacc_pkg::SUB_MODE), md[n]);
    end
    wr(CTL, 8'h00);
    wr(CTL, 8'h40);
    cyc(40);
    wr(CTL, 8'h0f);
    rchk(CTL, 8'h09, "match flags");
    chk({4'h0, module_pin_out}, 8'h05, "toggled pins");
    chk({4'h0, module_pin_oe_n}, 8'h0a, "pin drive");
    chk({7'h00, irq}, 8'h01, "match irq");
    $display("test compare done");
  endtask

  task automatic t_pwm();
    wr(ma(1, cacc_pkg::SUB_DUTY_AUX), 8'h00);
    wr(ma(1, cacc_pkg::SUB_VALUE_LOW), 8'h80);
    wr(ma(1, cacc_pkg::SUB_VALUE_HIGH), 8'h20);
    set_cnt(16'h0010);
    wr(ma(1, cacc_pkg::SUB_MODE), 8'h42);
    cyc(4);
    chk({7'h00, module_pin_out[1]}, 8'h00, "pwm below");
    chk({7'h00, module_pin_oe_n[1]}, 8'h00, "pwm drive");
    set_cnt(16'h0090);
    cyc(4);
    chk({7'h00, module_pin_out[1]}, 8'h01, "pwm above");
    wr(ma(1, cacc_pkg::SUB_DUTY_AUX), 8'h01);
    cyc(4);
    chk({7'h00, module_pin_out[1]}, 8'h00, "pwm ninth bit");
    wr(ma(1, cacc_pkg::SUB_DUTY_AUX), 8'h02);
    set_cnt(16'h00fe);
    wr(CTL, 8'h40);
    cyc(6);
    wr(CTL, 8'h00);
    rchk(ma(1, cacc_pkg::SUB_VALUE_LOW), 8'h20, "duty reload");
    rchk(ma(1, cacc_pkg::SUB_DUTY_AUX), 8'h03, "ninth reload");
    $display("test pwm done");
  endtask

  initial begin
    cyc(10);
    rst_n <= 1'b1;
    t_reset();
    t_counter();
    t_capture();
    t_compare();
    t_pwm();
    summarize();
  end

  // All tests take well under 2000 cycles
  initial begin
    cyc(5000);
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    summarize();
  end
endmodule // testbench
`default_nettype wire
